/* File: seew_defs.vh */
`ifndef SEEW_DEFS_VH
`define SEEW_DEFS_VH
// opcodes
`define SEEW_OP_SET_LATCH 8'h06
`define SEEW_OP_CLR_LATCH 8'h04
`define SEEW_OP_STAT_WR 8'h01
`define SEEW_OP_STAT_RD 8'h05
`define SEEW_OP_ARR_WR 8'h02
`define SEEW_OP_ARR_RD 8'h03
// array geometry: 1024 bytes, 16-byte pages
`define SEEW_ADDR_W 10
`define SEEW_ARRAY_WORDS 1024
`define SEEW_PAGE_OFS_W 4
`define SEEW_ADDR_MAX 10'h3ff
// status byte fields
`define SEEW_STAT_PROT_LSB 0
`define SEEW_STAT_PROT_MSB 2
`define SEEW_STAT_WDT_LSB 3
`define SEEW_STAT_WDT_MSB 4
`define SEEW_STAT_RESET 8'h18
// protection codes
`define SEEW_PROT_NONE 3'h0
`define SEEW_PROT_QTR1 3'h1
`define SEEW_PROT_QTR2 3'h2
`define SEEW_PROT_QTR3 3'h3
`define SEEW_PROT_QTR4 3'h4
`define SEEW_PROT_HALF_LO 3'h5
`define SEEW_PROT_PAGE_LO 3'h6
`define SEEW_PROT_PAGE_HI 3'h7
// watchdog codes
`define SEEW_WDT_LONG 2'h0
`define SEEW_WDT_MID 2'h1
`define SEEW_WDT_SHORT 2'h2
`define SEEW_WDT_OFF 2'h3
// times
`define SEEW_CLK_HZ 40000000
`define SEEW_WDT_LONG_MS 1400
`define SEEW_WDT_MID_MS 600
`define SEEW_WDT_SHORT_MS 200
`define SEEW_NV_WRITE_US 5000
`define SEEW_TICK_US 1000
// buffer
`define SEEW_FIFO_DEPTH 32
`define SEEW_FIFO_PTR_W 5
`define SEEW_FIFO_WIDTH 18
`endif

/* File: seew_fifo.v */
`timescale 1ns/100ps
// small synchronous fifo with valid/ready on both sides
module seew_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 32,
  parameter PTRW = 5
) (
  // clock and reset
  input wire clock,
  input wire rst_b,
  input wire flush,
  // fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTRW-1:0] wrPtr_r;
  reg [PTRW-1:0] rdPtr_r;
  reg [PTRW:0] count_r;
  wire doPush;
  wire doPop;

  // full and empty come straight from the occupancy count
  assign inReady = (count_r != DEPTH);
  assign outValid = (count_r != 0);
  assign outData = mem[rdPtr_r];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  // storage has no reset; only pointers and count need a defined value
  always @(posedge clock) begin
    if (doPush) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // pointers and count
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r <= {PTRW{1'b0}};
      rdPtr_r <= {PTRW{1'b0}};
      count_r <= {(PTRW+1){1'b0}};
    end else if (flush) begin
      wrPtr_r <= {PTRW{1'b0}};
      rdPtr_r <= {PTRW{1'b0}};
      count_r <= {(PTRW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doPop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      if (doPush && !doPop) begin
        count_r <= count_r + 1'b1;
      end else if (doPop && !doPush) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

/* File: seew_sync.v */
`timescale 1ns/100ps
// two-flop synchroniser for one level
module seew_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire clock,
  input wire rst_b,
  input wire asyncIn,
  output reg syncOut
);
  reg stage1_r;

  // first stage feeds only the second
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stage1_r <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      stage1_r <= asyncIn;
      syncOut <= stage1_r;
    end
  end
endmodule

/* File: seew_core.v */
`timescale 1ns/100ps
`include "seew_defs.vh"
// How it works
// RULE1: opcode 06 sets, 04 clears write latch
// RULE2: opcode 01 followed by one status byte
// RULE3: codes 001-100 protect one array quarter
// RULE4: code 101 protects lower half
// RULE5: code 110 lowest page, 111 highest
// RULE6: protected bytes readable, writes refused
// RULE7: protection held until next status write
// RULE8: opcode 03, 16-bit address, data out
// RULE9: read address increments, wraps to zero
// RULE10: chip select high ends read, output released
// RULE11: opcode 05 returns status and busy
// RULE12: enable opcode sent in own frame
// RULE13: enable without chip-select rise is ignored
// RULE14: opcode 02, address, data; 32 clocks minimum
// RULE15: master keeps chip select low throughout write
// RULE16: page data wraps within its page
// RULE17: write starts only on byte boundary rise
// RULE18: master sends zeros in bits 5-7
// RULE19: watchdog codes select 1.4s/600ms/200ms/off
// RULE20: new watchdog setting applies after next command; code waits for the next array read or write opcode (02 or 03)
// RULE21: master polls busy or waits 10ms
// RULE22: latch cleared at reset and after write
// RULE23: msb first, sample rise, shift fall
// RULE24: status msb is 1 while writing
// RULE25: chip select fall restarts watchdog count
// RULE26: status write also needs write latch
// RULE27: watchdog counts prescaled system clock ticks
module seew_core #(
  parameter NV_WRITE_TICKS = `SEEW_NV_WRITE_US / `SEEW_TICK_US,
  parameter TICK_CYCLES = `SEEW_CLK_HZ / 1000000 * `SEEW_TICK_US
) (
  // clock and reset
  input wire clock,
  input wire rst_b,
  // spi link pins
  input wire chipSel_b,
  input wire serClk,
  input wire serIn,
  output reg serOut,
  output reg serOutEn,
  // supervisor output, open drain style
  output reg wdtReset_b,
  output reg wdtResetEn,
  // observed state
  output reg busy,
  output reg writePermit,
  output reg [7:0] statusByte
);
  localparam ST_IDLE = 6'h01;
  localparam ST_OPC = 6'h02;
  localparam ST_ADDR = 6'h04;
  localparam ST_WDATA = 6'h08;
  localparam ST_RDATA = 6'h10;
  localparam ST_SDATA = 6'h20;
  localparam [10:0] WDT_LONG_T = `SEEW_WDT_LONG_MS * 1000 / `SEEW_TICK_US;
  localparam [10:0] WDT_MID_T = `SEEW_WDT_MID_MS * 1000 / `SEEW_TICK_US;
  localparam [10:0] WDT_SHORT_T = `SEEW_WDT_SHORT_MS * 1000 / `SEEW_TICK_US;

  // synchronised pins
  wire csS;
  wire sckS;
  wire siS;
  seew_sync #(.RESET_VAL(1'b1)) syncCs (.clock(clock), .rst_b(rst_b), .asyncIn(chipSel_b), .syncOut(csS));
  seew_sync #(.RESET_VAL(1'b0)) syncSck (.clock(clock), .rst_b(rst_b), .asyncIn(serClk), .syncOut(sckS));
  seew_sync #(.RESET_VAL(1'b0)) syncSi (.clock(clock), .rst_b(rst_b), .asyncIn(serIn), .syncOut(siS));

  reg csD_r;
  reg sckD_r;
  reg [5:0] state_r;
  reg [7:0] shift_r;
  reg [2:0] bitCnt_r;
  reg [7:0] opcode_r;
  reg addrHi_r;
  reg [`SEEW_ADDR_W-1:0] addr_r;
  reg [7:0] outByte_r;
  reg byteDone_r;
  reg stickyFrame_r;
  reg wdtPending_r;
  reg [1:0] wdtActive_r;
  reg [7:0] statNew_r;
  reg statWrPend_r;
  reg arrWrPend_r;
  reg [15:0] tickDiv_r;
  reg [12:0] nvCnt_r;
  reg [10:0] wdtCnt_r;
  reg commitGo_r;
  reg [7:0] mem [0:`SEEW_ARRAY_WORDS-1];

  wire sckRise = sckS && !sckD_r;
  wire sckFall = !sckS && sckD_r;
  wire csFall = !csS && csD_r;
  wire csRise = csS && !csD_r;
  wire [7:0] shiftNxt = {shift_r[6:0], siS};
  wire tick = (tickDiv_r == TICK_CYCLES - 1);
  wire [2:0] protCode = statusByte[`SEEW_STAT_PROT_MSB:`SEEW_STAT_PROT_LSB];
  wire [1:0] wdtCode = statusByte[`SEEW_STAT_WDT_MSB:`SEEW_STAT_WDT_LSB];

  // page buffer: full array address + data, drained into the array at commit
  wire fifoInReady;
  wire fifoOutValid;
  wire [`SEEW_FIFO_WIDTH-1:0] fifoOut;
  reg fifoPush;
  reg [`SEEW_FIFO_WIDTH-1:0] fifoIn;
  wire fifoPop = fifoOutValid && commitGo_r;
  seew_fifo #(.WIDTH(`SEEW_FIFO_WIDTH), .DEPTH(`SEEW_FIFO_DEPTH), .PTRW(`SEEW_FIFO_PTR_W)) pageBuf (
    .clock(clock),
    .rst_b(rst_b),
    .flush(csFall && !commitGo_r),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .inData(fifoIn),
    .outValid(fifoOutValid),
    .outReady(commitGo_r),
    .outData(fifoOut)
  );

  // protection decode per region code
  function isProtected;
    input [2:0] code;
    input [`SEEW_ADDR_W-1:0] a;
    begin
      case (code)
        `SEEW_PROT_QTR1: isProtected = (a[9:8] == 2'h0); // RULE3
        `SEEW_PROT_QTR2: isProtected = (a[9:8] == 2'h1); // RULE3
        `SEEW_PROT_QTR3: isProtected = (a[9:8] == 2'h2); // RULE3
        `SEEW_PROT_QTR4: isProtected = (a[9:8] == 2'h3); // RULE3
        `SEEW_PROT_HALF_LO: isProtected = (a[9] == 1'b0); // RULE4
        `SEEW_PROT_PAGE_LO: isProtected = (a[9:4] == 6'h00); // RULE5
        `SEEW_PROT_PAGE_HI: isProtected = (a[9:4] == 6'h3f); // RULE5
        default: isProtected = 1'b0; // RULE3
      endcase
    end
  endfunction

  // watchdog period lookup in ticks
  function [10:0] wdtLimit;
    input [1:0] code;
    begin
      case (code)
        `SEEW_WDT_LONG: wdtLimit = WDT_LONG_T; // RULE19
        `SEEW_WDT_MID: wdtLimit = WDT_MID_T; // RULE19
        default: wdtLimit = WDT_SHORT_T; // RULE19
      endcase
    end
  endfunction

  // array write port: only the commit drain writes
  always @(posedge clock) begin
    if (fifoPop) begin
      mem[fifoOut[17:8]] <= fifoOut[7:0];
    end
  end

  // edge history
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      csD_r <= 1'b1;
      sckD_r <= 1'b0;
    end else begin
      csD_r <= csS;
      sckD_r <= sckS;
    end
  end

  // fifo write source
  always @* begin
    fifoPush = 1'b0;
    fifoIn = {addr_r, shiftNxt};
    if (state_r == ST_WDATA && !csS && sckRise && bitCnt_r == 3'h7 && !busy) begin
      fifoPush = fifoInReady && !isProtected(protCode, addr_r); // RULE6
    end
  end

  // serial protocol engine
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      shift_r <= 8'h00;
      bitCnt_r <= 3'h0;
      opcode_r <= 8'h00;
      addrHi_r <= 1'b0;
      addr_r <= {`SEEW_ADDR_W{1'b0}};
      outByte_r <= 8'h00;
      byteDone_r <= 1'b0;
      stickyFrame_r <= 1'b0;
      writePermit <= 1'b0; // RULE22
      statNew_r <= 8'h00;
      statWrPend_r <= 1'b0;
      arrWrPend_r <= 1'b0;
      serOut <= 1'b0;
      serOutEn <= 1'b0;
      wdtPending_r <= 1'b0;
    end else if (csS) begin
      // frame over: release output and decide on commit
      serOutEn <= 1'b0; // RULE10
      state_r <= ST_IDLE;
      bitCnt_r <= 3'h0;
      if (csRise) begin
        if (state_r == ST_OPC && bitCnt_r == 3'h0 && !stickyFrame_r) begin
          if (opcode_r == `SEEW_OP_SET_LATCH) begin
            writePermit <= 1'b1; // RULE1 RULE12
          end else if (opcode_r == `SEEW_OP_CLR_LATCH) begin
            writePermit <= 1'b0; // RULE1
          end
        end
        if (byteDone_r && bitCnt_r == 3'h0 && (statWrPend_r || arrWrPend_r)) begin
          writePermit <= 1'b0; // RULE22
        end
      end
      statWrPend_r <= 1'b0;
      arrWrPend_r <= 1'b0;
    end else begin
      if (csFall) begin
        state_r <= ST_OPC;
        opcode_r <= 8'h00; // a latch opcode from the last frame must not mark this one
        stickyFrame_r <= 1'b0;
        byteDone_r <= 1'b0;
        bitCnt_r <= 3'h0;
      end
      if (sckRise && state_r != ST_IDLE) begin
        shift_r <= shiftNxt; // RULE23
        bitCnt_r <= bitCnt_r + 3'h1;
        byteDone_r <= (bitCnt_r == 3'h7);
        if (bitCnt_r == 3'h7) begin
          case (state_r)
            ST_OPC: begin
              opcode_r <= shiftNxt;
              addrHi_r <= 1'b1;
              if (shiftNxt == `SEEW_OP_SET_LATCH || shiftNxt == `SEEW_OP_CLR_LATCH) begin
                state_r <= ST_OPC;
              end else if (shiftNxt == `SEEW_OP_STAT_WR) begin
                state_r <= ST_SDATA; // RULE2
              end else if (shiftNxt == `SEEW_OP_STAT_RD) begin
                state_r <= ST_RDATA; // RULE11
                outByte_r <= busy ? 8'h80 : statusByte; // RULE24
              end else if (shiftNxt == `SEEW_OP_ARR_RD || shiftNxt == `SEEW_OP_ARR_WR) begin
                state_r <= ST_ADDR; // RULE8 RULE14
                wdtPending_r <= 1'b0; // RULE20
              end else begin
                state_r <= ST_IDLE;
              end
              if (opcode_r == `SEEW_OP_SET_LATCH || opcode_r == `SEEW_OP_CLR_LATCH) begin
                stickyFrame_r <= 1'b1; // RULE13
              end
            end
            ST_ADDR: begin
              addrHi_r <= 1'b0;
              if (addrHi_r) begin
                addr_r[9:8] <= shiftNxt[1:0];
              end else begin
                addr_r[7:0] <= shiftNxt;
                if (opcode_r == `SEEW_OP_ARR_RD) begin
                  state_r <= ST_RDATA;
                  outByte_r <= mem[{addr_r[9:8], shiftNxt}]; // RULE8
                  addr_r <= {addr_r[9:8], shiftNxt} + 10'h001; // RULE9
                end else begin
                  state_r <= ST_WDATA;
                end
              end
            end
            ST_WDATA: begin
              // wrap inside the page; a later byte overwrites on commit
              addr_r[3:0] <= addr_r[3:0] + 4'h1; // RULE16
              arrWrPend_r <= writePermit && !stickyFrame_r && !busy; // RULE13
            end
            ST_SDATA: begin
              statNew_r <= {3'h0, shiftNxt[4:0]}; // RULE18
              statWrPend_r <= writePermit && !stickyFrame_r && !busy; // RULE26
              state_r <= ST_IDLE;
            end
            ST_RDATA: begin
              if (opcode_r == `SEEW_OP_ARR_RD) begin
                outByte_r <= mem[addr_r];
                addr_r <= addr_r + 10'h001; // RULE9
                wdtPending_r <= 1'b0; // RULE20
              end else begin
                outByte_r <= busy ? 8'h80 : statusByte; // RULE11
              end
            end
            default: state_r <= ST_IDLE;
          endcase
        end
      end
      // stray clocks after a finished status byte cancel its commit
      if (sckRise && state_r == ST_IDLE) begin
        byteDone_r <= 1'b0; // RULE17
      end
      // shift out on falling edge, msb first
      if (sckFall && state_r == ST_RDATA) begin
        serOutEn <= 1'b1;
        serOut <= outByte_r[3'h7 - bitCnt_r]; // RULE23
      end
      if (statWrPend_r && !commitGo_r) begin
        wdtPending_r <= 1'b1;
      end
    end
  end

  // nonvolatile write timer and status commit
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      commitGo_r <= 1'b0;
      nvCnt_r <= 13'h0000;
      tickDiv_r <= 16'h0000;
      statusByte <= `SEEW_STAT_RESET;
      wdtActive_r <= `SEEW_WDT_OFF;
    end else begin
      tickDiv_r <= tick ? 16'h0000 : tickDiv_r + 16'h0001; // RULE27
      if (csRise && byteDone_r && bitCnt_r == 3'h0 && (statWrPend_r || arrWrPend_r)) begin
        commitGo_r <= 1'b1;
        busy <= 1'b1; // RULE17
        nvCnt_r <= 13'h0000;
        if (statWrPend_r) begin
          statusByte <= statNew_r; // RULE7
        end
      end else if (busy) begin
        if (tick) begin
          nvCnt_r <= nvCnt_r + 13'h0001;
        end
        if (nvCnt_r == NV_WRITE_TICKS && !fifoOutValid) begin
          commitGo_r <= 1'b0;
          busy <= 1'b0; // RULE24
        end
      end
      if (!wdtPending_r) begin
        wdtActive_r <= wdtCode; // RULE20
      end
    end
  end

  // watchdog counter, restarted by a chip select fall
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wdtCnt_r <= 11'h000;
      wdtReset_b <= 1'b1;
      wdtResetEn <= 1'b0;
    end else if (wdtActive_r == `SEEW_WDT_OFF || csFall) begin
      wdtCnt_r <= 11'h000; // RULE25
      wdtReset_b <= 1'b1;
      wdtResetEn <= 1'b0;
    end else if (tick) begin
      if (wdtCnt_r >= wdtLimit(wdtActive_r)) begin
        wdtReset_b <= 1'b0;
        wdtResetEn <= 1'b1;
      end else begin
        wdtCnt_r <= wdtCnt_r + 11'h001; // RULE27
      end
    end
  end

endmodule

/* File: seew_core_assertions.sv */
`timescale 1ns/100ps
// pin-level checker for the eeprom command core
module seew_core_chk #(
  parameter NV_WRITE_TICKS = 5,
  parameter TICK_CYCLES = 40
) (
  // clock and reset
  input wire clock,
  input wire rst_b,
  // link pins
  input wire chipSel_b,
  input wire serClk,
  input wire serIn,
  input wire serOut,
  input wire serOutEn,
  // supervisor and state
  input wire wdtReset_b,
  input wire wdtResetEn,
  input wire busy,
  input wire writePermit,
  input wire [7:0] statusByte
);
  int busyCnt_r;
  // length of the running write cycle, so its span can be bounded both ways
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      busyCnt_r <= 0;
    else
      busyCnt_r <= busy ? busyCnt_r + 1 : 0;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_oe_idle_off: assert property (chipSel_b [*8] |-> !serOutEn)
    else $error("data out driven while deselected");
  a_oe_start_sel: assert property ($rose(serOutEn) |-> !chipSel_b)
    else $error("data out enabled outside a frame");
  a_write_on_rise: assert property ($rose(busy) |-> chipSel_b && !serClk)
    else $error("write began while selected");
  a_busy_max_len: assert property (busyCnt_r <= (NV_WRITE_TICKS + 1) * TICK_CYCLES)
    else $error("write cycle too long");
  a_busy_min_len: assert property ($fell(busy) |-> busyCnt_r >= (NV_WRITE_TICKS - 1) * TICK_CYCLES)
    else $error("write cycle too short");
  a_latch_after_wr: assert property ($fell(busy) |-> !writePermit)
    else $error("write latch left set after write");
  a_latch_set_rise: assert property ($rose(writePermit) |-> chipSel_b)
    else $error("write latch set inside a frame");
  a_status_held: assert property (!$stable(statusByte) |-> chipSel_b)
    else $error("status byte changed mid-frame");
  a_status_top_zero: assert property (statusByte[7:5] == 3'h0)
    else $error("status top bits not zero");
endmodule
bind seew_core seew_core_chk #(.NV_WRITE_TICKS(NV_WRITE_TICKS), .TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clock(clock), .rst_b(rst_b), .chipSel_b(chipSel_b), .serClk(serClk), .serIn(serIn),
  .serOut(serOut), .serOutEn(serOutEn), .wdtReset_b(wdtReset_b), .wdtResetEn(wdtResetEn),
  .busy(busy), .writePermit(writePermit), .statusByte(statusByte));

/* File: seew_spi_master.sv */
`timescale 1ns/100ps
// microcontroller side of the link, mode 0, clock parked low between frames
module seew_spi_master (
  // pacing clock
  input wire clock,
  // link pins
  output logic chipSel_b,
  output logic serClk,
  output logic serIn,
  input wire serOut
);
  // deselected and quiet until the first frame
  initial begin
    chipSel_b = 1'b1;
    serClk = 1'b0;
    serIn = 1'b0;
  end
  // one frame of n bits; four clocks a half period gives the 200 ns link clock
  task automatic frame(input int n, input logic [159:0] tx, output logic [159:0] rx);
    rx = '0;
    @(negedge clock) chipSel_b = 1'b0;
    repeat (4) @(negedge clock);
    for (int i = n - 1; i >= 0; i--) begin
      serIn = tx[i];
      repeat (4) @(negedge clock);
      serClk = 1'b1;
      repeat (4) @(negedge clock);
      rx[i] = serOut; // still held from the previous fall
      serClk = 1'b0;
    end
    repeat (4) @(negedge clock);
    chipSel_b = 1'b1;
    serIn = ~serIn; // released line shows no stale bit
    repeat (12) @(negedge clock);
  endtask
endmodule

/* File: tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; $display("wrong value at %0t: %h vs %h", $time, g, e); end end
// self-checking bench for the eeprom command core
module tb;
  // clock, reset and pins
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  wire chipSel_b, serClk, serIn, serOut, serOutEn, wdtReset_b, wdtResetEn, busy, writePermit;
  wire [7:0] statusByte;
  // released data line reads inverted, never the last bit
  wire soLine = serOutEn ? serOut : ~serOut;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [159:0] rx;
  logic [159:0] tx;
  logic [7:0] expMem [6];
  logic [9:0] probe [6] = '{10'h00f, 10'h0ff, 10'h100, 10'h2ff, 10'h300, 10'h3f0};
  seew_core #(.TICK_CYCLES(40)) u_seew_core (.clock(clock), .rst_b(rst_b), .chipSel_b(chipSel_b),
    .serClk(serClk), .serIn(serIn), .serOut(serOut), .serOutEn(serOutEn), .wdtReset_b(wdtReset_b),
    .wdtResetEn(wdtResetEn), .busy(busy), .writePermit(writePermit), .statusByte(statusByte));
  seew_spi_master u_seew_spi_master (.clock(clock), .chipSel_b(chipSel_b), .serClk(serClk),
    .serIn(serIn), .serOut(soLine));
  // 40 MHz
  always #12.5 clock = ~clock;
  // hang guard, well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic xf(input int n, input logic [159:0] t);
    u_seew_spi_master.frame(n, t, rx);
  endtask
  // poll status until the write-in-progress bit clears
  task automatic settle();
    for (int k = 0; k < 20; k++) begin
      xf(16, 16'h0500);
      if (rx[7] === 1'b0) return;
    end
    `CHK(1'b1, 1'b0)
  endtask
  // latch in its own frame, then the array write; upper address bits zero
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    xf(8, 8'h06);
    xf(32, {8'h02, 6'h00, a, d});
  endtask
  task automatic rd(input logic [9:0] a);
    xf(32, {8'h03, 6'h00, a, 8'h00});
  endtask
  function automatic bit locked(int c, logic [9:0] a);
    case (c)
      1: return a < 10'h100;
      2: return a[9:8] == 2'h1;
      3: return a[9:8] == 2'h2;
      4: return a[9:8] == 2'h3;
      5: return a < 10'h200;
      6: return a < 10'h010;
      7: return a >= 10'h3f0;
      default: return 1'b0;
    endcase
  endfunction
  task automatic t_reset();
    `CHK(writePermit, 1'b0)
    `CHK(wdtReset_b, 1'b1)
    xf(16, 16'h0500);
    `CHK(rx[7:0], 8'h18)
    $display("test reset done");
  endtask
  task automatic t_latch();
    xf(8, 8'h06);
    `CHK(writePermit, 1'b1)
    xf(8, 8'h04);
    `CHK(writePermit, 1'b0)
    xf(16, 16'h011d);
    `CHK(statusByte, 8'h18)
    $display("test latch done");
  endtask
  // every protection code against probes on the region edges except 1ff/200
  task automatic t_prot();
    for (int c = 0; c < 8; c++) begin
      xf(8, 8'h06);
      xf(16, {8'h01, 5'h03, c[2:0]});
      settle();
      `CHK(statusByte, {5'h03, c[2:0]})
      for (int i = 0; i < 6; i++) begin
        wr(probe[i], {c[3:0], i[3:0]});
        settle();
        if (!locked(c, probe[i])) expMem[i] = {c[3:0], i[3:0]};
        rd(probe[i]);
        `CHK(rx[7:0], expMem[i])
      end
    end
    xf(8, 8'h06);
    xf(16, 16'h0118);
    settle();
    $display("test protection done");
  endtask
  // page wrap, read wrap, busy report, aborted and unframed writes
  task automatic t_page();
    wr(10'h000, 8'h5a);
    settle();
    tx = '0;
    tx[159:136] = 24'h0203ff;
    for (int k = 0; k < 17; k++) tx[135 - 8 * k -: 8] = 8'h80 + k[7:0];
    xf(8, 8'h06);
    xf(160, tx);
    xf(16, 16'h0500);
    `CHK(rx[7], 1'b1)
    settle();
    xf(48, {8'h03, 16'h03fe, 24'h0});
    `CHK(rx[23:8], 16'h8f90)
    `CHK(rx[7:0], 8'h5a)
    `CHK(serOutEn, 1'b0)
    xf(8, 8'h06);
    xf(28, {8'h02, 16'h0000, 4'ha});
    `CHK(busy, 1'b0)
    `CHK(writePermit, 1'b1)
    xf(40, {8'h06, 8'h02, 16'h0000, 8'h33});
    settle();
    rd(10'h000);
    `CHK(rx[7:0], 8'h5a)
    $display("test page done");
  endtask
  // short period held back until an array command, then expiry from the last select
  task automatic t_wdt();
    xf(8, 8'h06);
    xf(16, 16'h0110);
    settle();
    repeat (8400) @(negedge clock);
    `CHK(wdtReset_b, 1'b1)
    rd(10'h000);
    repeat (7000) @(negedge clock);
    `CHK(wdtReset_b, 1'b1)
    for (int k = 0; k < 1500 && wdtReset_b !== 1'b0; k++) @(negedge clock);
    `CHK(wdtReset_b, 1'b0)
    `CHK(wdtResetEn, 1'b1)
    $display("test watchdog done");
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    t_reset();
    t_latch();
    t_prot();
    t_page();
    t_wdt();
    give_verdict();
  end
endmodule
